// ===== logic/chs_pkg.sv
// chs_pkg: addresses, field positions, codes and reset values of the
// charger status register bank.
// assumes: the register read port of the bank uses 8-bit addresses.
package chs_pkg;
  localparam logic [7:0] ADDR_COND = 8'h1D;
  localparam logic [7:0] ADDR_PHASE = 8'h1E;
  localparam logic [7:0] ADDR_FAULT = 8'h1F;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // condition status register bit positions
  localparam int COND_ADC_DONE = 6;
  localparam int COND_DIE_THERMAL = 5;
  localparam int COND_MIN_SYS = 4;
  localparam int COND_IN_CURRENT = 3;
  localparam int COND_IN_VOLTAGE = 2;
  localparam int COND_CHG_TIMER = 1;
  localparam int COND_WATCHDOG = 0;

  // phase and source status register field positions
  localparam int PHASE_LSB = 3;
  localparam int SOURCE_LSB = 0;

  // fault status register bit positions
  localparam int FAULT_INPUT = 7;
  localparam int FAULT_BATTERY = 6;
  localparam int FAULT_SYSTEM = 5;
  localparam int FAULT_BOOST = 4;
  localparam int FAULT_SHUTDOWN = 3;
  localparam int ZONE_LSB = 0;

  localparam logic [2:0] SOURCE_NONE = 3'h0;
  localparam logic [2:0] SOURCE_OTG = 3'h7;

  // number of raw condition wires that cross into the register clock
  localparam int RAW_W = 29;
endpackage

// ===== logic/chs_status_regs.sv
// chs_status_regs: three read-only charger status registers with a
// rising-edge pulse per status bit for the latched flag bank.
// assumes: condition inputs come from analog/core logic on another clock,
// the serial-interface engine issues single-cycle read and write strobes.
//
// Summary of operation
// - conversion-complete in one-shot only, zero when continuous
// - bit5 shows die thermal regulation active
// - bit4 shows minimum system regulation, forward mode
// - bit3 input/pin current loop or boost current
// - bit2 input voltage loop or boost voltage
// - bit1 shows safety timer expired
// - bit0 shows host watchdog expired
// - bits4:3 report the charge phase code
// - bits2:0 source type, 000 undetected, 111 boost
// - fault bit7 input overvoltage or sleep
// - fault bit6 battery overcurrent or overvoltage
// - fault bit5 system rail short or overvoltage
// - fault bit4 boost mid-rail/input fault during boost
// - fault bit3 die thermal shutdown
// - fault bits2:0 report thermistor zone code
// - pulse on each status bit rising edge
`timescale 1ns/1ps
module chs_status_regs (
  input wire logic mclk,
  input wire logic nrst,
  // register port from the serial-interface engine
  input wire logic rdEn,
  input wire logic wrEn,
  input wire logic [7:0] addr,
  output logic [7:0] rdData,
  output logic rdAck,
  output logic wrAck,
  output logic [23:0] statusRise,
  // raw conditions from the charger core
  input wire logic adcOneShotDone,
  input wire logic adcContinuous,
  input wire logic dieThermalLimit,
  input wire logic minSysRailReg,
  input wire logic inputCurrentLoop,
  input wire logic externalCurrentLimitPinLoop,
  input wire logic boostCurrentLoop,
  input wire logic inputVoltageLoop,
  input wire logic boostVoltageLoop,
  input wire logic chargeTimerExpired,
  input wire logic hostWatchdogExpired,
  input wire logic otgMode,
  input wire logic backupMode,
  input wire logic [1:0] chargePhase,
  input wire logic [2:0] sourceType,
  input wire logic autoSourceDetectEnable,
  input wire logic inputRailFault,
  input wire logic batteryOverCurrent,
  input wire logic batteryOverVoltage,
  input wire logic sysShort,
  input wire logic sysOverVoltage,
  input wire logic boostFault,
  input wire logic dieOvertempShutdown,
  input wire logic [2:0] thermistorZone
);
  localparam int RW = chs_pkg::RAW_W;

  logic [RW-1:0] rawIn;
  logic [RW-1:0] sync1_q;
  logic [RW-1:0] sync2_q;
  logic adcDoneS, adcContS, thermS, vsysS, iinS, ilimS, iotgS, vinS, votgS;
  logic timerS, wdS, otgS, backupS, autoS, vbusFltS, batOcS, batOvS;
  logic sysShS, sysOvS, boostFltS, tshutS;
  logic [1:0] phaseS;
  logic [2:0] sourceS, zoneS;
  logic [7:0] fieldPrev_q;
  logic [1:0] phaseHold_q;
  logic [2:0] sourceHold_q, zoneHold_q;
  logic phaseStable, sourceStable, zoneStable, forwardMode;
  logic [7:0] condD, phaseD, faultD;
  logic [23:0] stat_d, stat_q;
  logic [7:0] rdMux;
  logic [7:0] rdData_q;
  logic rdAck_q, wrAck_q;
  logic [23:0] statusRise_q;

  assign rawIn = {adcOneShotDone, adcContinuous, dieThermalLimit, minSysRailReg,
    inputCurrentLoop, externalCurrentLimitPinLoop, boostCurrentLoop, inputVoltageLoop,
    boostVoltageLoop, chargeTimerExpired, hostWatchdogExpired, otgMode, backupMode,
    autoSourceDetectEnable, inputRailFault, batteryOverCurrent, batteryOverVoltage,
    sysShort, sysOverVoltage, boostFault, dieOvertempShutdown,
    chargePhase, sourceType, thermistorZone};

  // two-stage synchroniser per condition wire
  for (genvar i = 0; i < RW; i++) begin : g_sync
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= rawIn[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  assign {adcDoneS, adcContS, thermS, vsysS, iinS, ilimS, iotgS, vinS, votgS,
    timerS, wdS, otgS, backupS, autoS, vbusFltS, batOcS, batOvS, sysShS, sysOvS,
    boostFltS, tshutS, phaseS, sourceS, zoneS} = sync2_q;

  // bits of a field may resolve on different edges; a field is taken only
  // after it has read the same for two cycles, so a mixed code never shows
  assign phaseStable = phaseS == fieldPrev_q[7:6];
  assign sourceStable = sourceS == fieldPrev_q[5:3];
  assign zoneStable = zoneS == fieldPrev_q[2:0];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fieldPrev_q <= 8'h00;
      phaseHold_q <= 2'h0;
      sourceHold_q <= 3'h0;
      zoneHold_q <= 3'h0;
    end else begin
      fieldPrev_q <= {phaseS, sourceS, zoneS};
      if (phaseStable) phaseHold_q <= phaseS;
      if (sourceStable) sourceHold_q <= sourceS;
      if (zoneStable) zoneHold_q <= zoneS;
    end
  end

  assign forwardMode = !otgS && !backupS;

  always_comb begin
    condD = chs_pkg::STATUS_RESET;
    condD[chs_pkg::COND_ADC_DONE] = adcDoneS && !adcContS;
    condD[chs_pkg::COND_DIE_THERMAL] = thermS;
    condD[chs_pkg::COND_MIN_SYS] = forwardMode && vsysS;
    condD[chs_pkg::COND_IN_CURRENT] = otgS ? iotgS : (forwardMode && (iinS || ilimS));
    condD[chs_pkg::COND_IN_VOLTAGE] = forwardMode ? vinS : votgS;
    condD[chs_pkg::COND_CHG_TIMER] = timerS;
    condD[chs_pkg::COND_WATCHDOG] = wdS;
    phaseD = chs_pkg::STATUS_RESET;
    phaseD[chs_pkg::PHASE_LSB +: 2] = phaseHold_q;
    if (otgS) begin
      phaseD[chs_pkg::SOURCE_LSB +: 3] = chs_pkg::SOURCE_OTG;
    end else if (autoS) begin
      phaseD[chs_pkg::SOURCE_LSB +: 3] = sourceHold_q;
    end else begin
      phaseD[chs_pkg::SOURCE_LSB +: 3] = chs_pkg::SOURCE_NONE;
    end
    faultD = chs_pkg::STATUS_RESET;
    faultD[chs_pkg::FAULT_INPUT] = vbusFltS;
    faultD[chs_pkg::FAULT_BATTERY] = batOcS || batOvS;
    faultD[chs_pkg::FAULT_SYSTEM] = sysShS || sysOvS;
    faultD[chs_pkg::FAULT_BOOST] = otgS && boostFltS;
    faultD[chs_pkg::FAULT_SHUTDOWN] = tshutS;
    faultD[chs_pkg::ZONE_LSB +: 3] = zoneHold_q;
  end

  assign stat_d = {faultD, phaseD, condD};

  // unmapped addresses read zero; reserved bits are zero in stat_q already
  assign rdMux = (addr == chs_pkg::ADDR_COND) ? stat_q[7:0] :
                 (addr == chs_pkg::ADDR_PHASE) ? stat_q[15:8] :
                 (addr == chs_pkg::ADDR_FAULT) ? stat_q[23:16] :
                 chs_pkg::UNMAPPED_DATA;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= {3{chs_pkg::STATUS_RESET}};
      statusRise_q <= 24'h000000;
    end else begin
      stat_q <= stat_d;
      statusRise_q <= stat_d & ~stat_q;
    end
  end

  // writes without a read strobe in the same cycle are acknowledged so the serial engine completes, but store nothing
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdData_q <= 8'h00;
      rdAck_q <= 1'b0;
      wrAck_q <= 1'b0;
    end else begin
      rdAck_q <= rdEn;
      wrAck_q <= wrEn && !rdEn;
      if (rdEn) rdData_q <= rdMux;
    end
  end

  assign rdData = rdData_q;
  assign rdAck = rdAck_q;
  assign wrAck = wrAck_q;
  assign statusRise = statusRise_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_adc_cont;
    adcContS |=> !stat_q[chs_pkg::COND_ADC_DONE];
  endproperty
  a_adc_cont: assert property (p_adc_cont) else $error("adc done set in continuous");

  property p_thermal;
    ##1 stat_q[chs_pkg::COND_DIE_THERMAL] == $past(thermS);
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal bit mismatch");

  property p_minsys;
    (forwardMode && vsysS) |=> stat_q[chs_pkg::COND_MIN_SYS];
  endproperty
  a_minsys: assert property (p_minsys) else $error("min system bit missed");

  property p_otg_current;
    (otgS && !iotgS) |=> !stat_q[chs_pkg::COND_IN_CURRENT];
  endproperty
  a_otg_current: assert property (p_otg_current) else $error("current bit wrong in boost");

  property p_boost_voltage_target;
    (backupS && votgS) |=> stat_q[chs_pkg::COND_IN_VOLTAGE];
  endproperty
  a_boost_voltage_target: assert property (p_boost_voltage_target) else $error("voltage bit missed in backup");

  property p_timer_wd;
    (timerS && wdS) |=> stat_q[1:0] == 2'h3;
  endproperty
  a_timer_wd: assert property (p_timer_wd) else $error("timer or watchdog bit missed");

  property p_source_otg;
    otgS |=> stat_q[10:8] == chs_pkg::SOURCE_OTG;
  endproperty
  a_source_otg: assert property (p_source_otg) else $error("source not 111 in boost");

  property p_source_off;
    (!otgS && !autoS) |=> stat_q[10:8] == chs_pkg::SOURCE_NONE;
  endproperty
  a_source_off: assert property (p_source_off) else $error("source not 000 when off");

  property p_boost_fault;
    !otgS |=> !stat_q[16 + chs_pkg::FAULT_BOOST];
  endproperty
  a_boost_fault: assert property (p_boost_fault) else $error("boost fault outside boost");

  property p_faults;
    (batOvS && sysShS && tshutS) |=> stat_q[22] && stat_q[21] && stat_q[19];
  endproperty
  a_faults: assert property (p_faults) else $error("fault bits missed");

  property p_rise;
    $rose(stat_q[5]) |-> statusRise_q[5];
  endproperty
  a_rise: assert property (p_rise) else $error("rise pulse missed");

  property p_rise_only;
    statusRise_q[19] |-> stat_q[19] && !$past(stat_q[19]);
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("spurious rise pulse");

  // bit 7 of the fault register is a live bit, so only the other addresses are checked
  property p_reserved;
    (rdEn && addr != chs_pkg::ADDR_FAULT) |=> rdAck_q && rdData_q[7] == 1'b0 &&
      ($past(addr) != chs_pkg::ADDR_PHASE || rdData_q[6:5] == 2'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit read nonzero");

  property p_phase_stable;
    $changed(phaseHold_q) |-> $past(phaseS) == $past(fieldPrev_q[7:6]);
  endproperty
  a_phase_stable: assert property (p_phase_stable) else $error("phase taken unsettled");

  property p_phase_code;
    (phaseS == fieldPrev_q[7:6]) |-> ##2 stat_q[8 + chs_pkg::PHASE_LSB +: 2] == $past(phaseS, 2);
  endproperty
  a_phase_code: assert property (p_phase_code) else $error("phase code not carried");

  property p_zone_code;
    (zoneS == fieldPrev_q[2:0]) |-> ##2 stat_q[16 + chs_pkg::ZONE_LSB +: 3] == $past(zoneS, 2);
  endproperty
  a_zone_code: assert property (p_zone_code) else $error("zone code not carried");

  property p_input_fault;
    ##1 stat_q[16 + chs_pkg::FAULT_INPUT] == $past(vbusFltS);
  endproperty
  a_input_fault: assert property (p_input_fault) else $error("input fault bit mismatch");

  property p_sys_fault;
    (sysOvS && !sysShS) |=> stat_q[16 + chs_pkg::FAULT_SYSTEM];
  endproperty
  a_sys_fault: assert property (p_sys_fault) else $error("system overvoltage missed");

  property p_shutdown;
    !tshutS |=> !stat_q[16 + chs_pkg::FAULT_SHUTDOWN];
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown bit without cause");

  property p_timer;
    ##1 stat_q[chs_pkg::COND_CHG_TIMER] == $past(timerS);
  endproperty
  a_timer: assert property (p_timer) else $error("timer bit mismatch");

  property p_minsys_off;
    !forwardMode |=> !stat_q[chs_pkg::COND_MIN_SYS];
  endproperty
  a_minsys_off: assert property (p_minsys_off) else $error("min system bit outside forward");

  c_otg_read: cover property (otgS ##2 rdEn && addr == chs_pkg::ADDR_PHASE);
  c_thermal_rise: cover property (statusRise_q[5]);
  c_fault_read: cover property (rdEn && addr == chs_pkg::ADDR_FAULT ##1 rdData_q != 8'h00);
  c_write_ignored: cover property (wrEn ##1 wrAck_q);
endmodule

// ===== tb/chs_host_model.sv
// chs_host_model: host side of the status register port, one access at a time.
// assumes: the bank answers a read or write strobe on the following cycle.
`timescale 1ns/1ps
module chs_host_model (
  input wire logic mclk,
  output logic rdEn,
  output logic wrEn,
  output logic [7:0] addr,
  input wire logic [7:0] rdData,
  input wire logic rdAck,
  input wire logic wrAck
);
  initial begin
    rdEn = 1'b0;
    wrEn = 1'b0;
    addr = 8'h00;
  end

  // strobes last one cycle; the address is held until the answer is seen
  task automatic acc(input logic w, input logic [7:0] a, input int gap,
                     output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    repeat (gap) @(posedge mclk);
    rdEn <= !w;
    wrEn <= w;
    addr <= a;
    @(posedge mclk);
    rdEn <= 1'b0;
    wrEn <= 1'b0;
    // the answer is taken at the edge at which it is sampled high
    @(posedge mclk);
    while ((w ? wrAck : rdAck) !== 1'b1 && n < 4) begin
      @(posedge mclk);
      n++;
    end
    d = rdData;
    ok = w ? wrAck : rdAck;
  endtask
endmodule

// ===== tb/chs_status_regs_tb.sv
// chs_status_regs_tb: random condition sweep compared with a behavioural model.
// assumes: every condition change settles within 8 cycles of the register clock.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module chs_status_regs_tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic rdEn, wrEn, rdAck, wrAck;
  logic [7:0] addr, rdData;
  logic [23:0] statusRise;
  logic [20:0] v = '0;
  logic [1:0] ph = '0;
  logic [2:0] st = '0;
  logic [2:0] tz = '0;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int seenRise = 0;
  int expRise = 0;

  always #12.5 mclk = ~mclk;

  chs_host_model i_host (.mclk(mclk), .rdEn(rdEn), .wrEn(wrEn), .addr(addr),
    .rdData(rdData), .rdAck(rdAck), .wrAck(wrAck));

  chs_status_regs i_dut (.mclk(mclk), .nrst(nrst), .rdEn(rdEn), .wrEn(wrEn), .addr(addr),
    .rdData(rdData), .rdAck(rdAck), .wrAck(wrAck), .statusRise(statusRise),
    .adcOneShotDone(v[0]), .adcContinuous(v[1]), .dieThermalLimit(v[2]),
    .minSysRailReg(v[3]), .inputCurrentLoop(v[4]), .externalCurrentLimitPinLoop(v[5]),
    .boostCurrentLoop(v[6]), .inputVoltageLoop(v[7]), .boostVoltageLoop(v[8]),
    .chargeTimerExpired(v[9]), .hostWatchdogExpired(v[10]), .otgMode(v[11]),
    .backupMode(v[12]), .chargePhase(ph), .sourceType(st), .autoSourceDetectEnable(v[13]),
    .inputRailFault(v[14]), .batteryOverCurrent(v[15]), .batteryOverVoltage(v[16]),
    .sysShort(v[17]), .sysOverVoltage(v[18]), .boostFault(v[19]),
    .dieOvertempShutdown(v[20]), .thermistorZone(tz));

  // expected bytes {fault, phase/source, condition}
  function automatic logic [23:0] model();
    logic fwd;
    logic [2:0] src;
    fwd = !v[11] && !v[12];
    src = v[11] ? chs_pkg::SOURCE_OTG : (!v[13] ? chs_pkg::SOURCE_NONE : st);
    return {v[14], v[15] | v[16], v[17] | v[18], v[19] & v[11], v[20], tz,
      3'h0, ph, src,
      1'b0, v[0] & !v[1], v[2], v[3] & fwd, fwd ? (v[4] | v[5]) : (v[11] & v[6]),
      fwd ? v[7] : v[8], v[9], v[10]};
  endfunction

  task automatic end_sim();
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check_all(input logic [23:0] e);
    logic [7:0] d;
    logic ok;
    for (int k = 0; k < 3; k++) begin
      i_host.acc(1'b0, chs_pkg::ADDR_COND + 8'(k), 0, d, ok);
      `CHK("rdAck", 1'b1, ok)
      `CHK("status", e[8*k +: 8], d)
    end
  endtask

  // the source field may show the previously held code for two cycles when autoSourceDetectEnable rises, so only single bits are counted
  always @(posedge mclk) begin
    cyc++;
    seenRise += $countones(statusRise & 24'hF800FF);
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    logic [23:0] e;
    logic [23:0] prev;
    logic [31:0] r;
    logic [7:0] d;
    logic ok;
    prev = '0;
    void'($urandom(32'h50214307));
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    check_all({3{chs_pkg::STATUS_RESET}});
    for (int i = 0; i < 40; i++) begin
      r = $urandom;
      if (r[11]) r[12] = 1'b0;
      @(posedge mclk);
      v <= r[20:0];
      ph <= i[1:0];
      tz <= i[2:0];
      st <= 3'(i * 3);
      repeat (8) @(posedge mclk);
      e = model();
      expRise += $countones(e & ~prev & 24'hF800FF);
      prev = e;
      check_all(e);
      i_host.acc(1'b1, chs_pkg::ADDR_COND + 8'(i % 3), i % 3, d, ok);
      `CHK("wrAck", 1'b1, ok)
      i_host.acc(1'b0, chs_pkg::ADDR_COND + 8'(i % 3), 0, d, ok);
      `CHK("afterWrite", e[8*(i%3) +: 8], d)
      i_host.acc(1'b0, 8'h20 + 8'(r[31:29]), 0, d, ok);
      `CHK("unmapped", chs_pkg::UNMAPPED_DATA, d)
    end
    repeat (4) @(posedge mclk);
    `CHK("riseCount", expRise, seenRise)
    end_sim();
  end
endmodule
